// >>> csoi_pkg.sv
// constants and types of the core status, option and interrupt register group
// Overview of operation
// (R1) bank select 00 picks lower 128-byte data bank, 01 picks upper bank
// (R2) software keeps upper direct and indirect bank select bits cleared
// (R3) timeout_n reads 1 after power-up, watchdog clear, sleep; 0 after time-out
// (R4) powerdown_n set at power-up or watchdog clear, cleared by sleep
// (R5) zero flag set on zero arithmetic or logic result, else cleared
// (R6) digit carry captures carry out of bit 3; inverted borrow on subtract
// (R7) carry captures carry out of msb; subtract adds two's complement
// (R8) rotates load carry with the source bit shifted out
// (R9) pull-up disable 1 turns off all port B pull-ups, else per latch
// (R10) external pin interrupt on rising edge when edge select 1, else falling
// (R11) timer0 counts pin transitions when source bit 1, else instruction cycles
// (R12) external mode: increment on falling edge when source edge 1, else rising
// (R13) prescaler goes to watchdog when assign bit 1, else to timer0
// (R14) rate field: timer0 1:2 to 1:256, watchdog 1:1 to 1:128
// (R15) software assigns prescaler to watchdog for undivided timer0 count
// (R16) flags set on their condition regardless of enables; software clears first
// (R17) global enable 1 allows unmasked interrupts, 0 blocks all
// (R18) peripheral enable must be 1 for any peripheral interrupt
// (R19) control word: enables bits 5..3, flags bits 2..0; software clears flags
// (R20) peripheral enable word bits 6,3..0; bits 7,5,4 read 0
// (R21) flag-altering instruction to status discards written flag bits
// (R22) status and control word reachable at same offset in either bank
// (R23) request when flag and enable and global enable; peripherals need peripheral enable
package csoi_pkg;

  localparam logic [7:0] STATUS_OFS  = 8'h03;
  localparam logic [7:0] IRQCTL_OFS  = 8'h0b;
  localparam logic [7:0] OPTION_OFS  = 8'h81;
  localparam logic [7:0] PIE_OFS     = 8'h8c;
  localparam logic [6:0] BANK_MASK   = 7'h7f;

  localparam logic [7:0] STATUS_RST  = 8'h18;
  localparam logic [7:0] IRQCTL_RST  = 8'h00;
  localparam logic [7:0] OPTION_RST  = 8'hff;
  localparam logic [7:0] PIE_RST     = 8'h00;
  localparam logic [7:0] PIE_MASK    = 8'h4f;

  localparam int GLOBAL_EN_BIT = 7;
  localparam int PERIPH_EN_BIT = 6;
  localparam int EN_LSB        = 3;
  localparam int EN_MSB        = 5;
  localparam int FL_LSB        = 0;
  localparam int FL_MSB        = 2;
  localparam int T0_FLAG       = 2;
  localparam int EXT_FLAG      = 1;
  localparam int PC_FLAG       = 0;
  localparam int NIBBLE_MSB    = 3;

  typedef enum logic [2:0] {
    ALU_NONE,
    ALU_ADD,
    ALU_SUB,
    ALU_LOGIC,
    ALU_ROTL,
    ALU_ROTR
  } csoi_alu_e;

  typedef enum logic [2:0] {
    SEL_NONE,
    SEL_STATUS,
    SEL_IRQCTL,
    SEL_OPTION,
    SEL_PIE
  } csoi_sel_e;

  typedef struct packed {
    logic indirectBankSelect;
    logic directBankSelectHi;
    logic directBankSelectLo;
    logic timeoutStatusN;
    logic powerdownStatusN;
    logic zeroFlag;
    logic digitCarryFlag;
    logic carryFlag;
  } csoi_status_s;

  typedef struct packed {
    logic       portbPullupDisable;
    logic       extIrqEdgeSelect;
    logic       timer0ClockSource;
    logic       timer0SourceEdge;
    logic       prescalerAssign;
    logic [2:0] prescalerRate;
  } csoi_option_s;

endpackage

// >>> csoi_regs.sv
// core status, option and interrupt control register group
`timescale 1ns/1ps
module csoi_regs
(
  // clock and reset
  input  wire logic                clk,
  input  wire logic                reset_n,
  // register access from instruction execution
  input  wire logic [6:0]          regAddr,
  input  wire logic                regWrEn,
  input  wire logic [7:0]          regWrData,
  output logic      [7:0]          regRdData,
  output logic      [7:0]          dataAddr,
  // alu flag update
  input  csoi_pkg::csoi_alu_e      aluOp,
  input  wire logic [7:0]          aluOperandF,
  input  wire logic [7:0]          aluOperandW,
  input  wire logic [7:0]          aluLogicResult,
  // power and watchdog events
  input  wire logic                watchdogClearInstruction,
  input  wire logic                sleepInstruction,
  input  wire logic                watchdogTimeout,
  input  wire logic                watchdogOscTick,
  output logic                     watchdogTick,
  // pins and peripheral events
  input  wire logic                extInterruptPin,
  input  wire logic                timer0ClockPin,
  input  wire logic                instrCycleTick,
  input  wire logic                portChangeEvent,
  input  wire logic [7:0]          portbLatch,
  input  wire logic [7:0]          periphFlags,
  output logic      [7:0]          portbPullupOn,
  output logic      [7:0]          timer0Count,
  // status and interrupt request
  output csoi_pkg::csoi_status_s   statusWord,
  output logic                     irqRequest
);

  // ------------------------------------------------------------
  // address decode
  // ------------------------------------------------------------
  function automatic csoi_pkg::csoi_sel_e regSel(input logic [7:0] a);
    csoi_pkg::csoi_sel_e s;
    s = csoi_pkg::SEL_NONE;
    if (a[6:0] == csoi_pkg::STATUS_OFS[6:0])
      s = csoi_pkg::SEL_STATUS; // R22
    else if (a[6:0] == csoi_pkg::IRQCTL_OFS[6:0])
      s = csoi_pkg::SEL_IRQCTL; // R22
    else if (a == csoi_pkg::OPTION_OFS)
      s = csoi_pkg::SEL_OPTION;
    else if (a == csoi_pkg::PIE_OFS)
      s = csoi_pkg::SEL_PIE;
    return s;
  endfunction

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  csoi_pkg::csoi_status_s status_q, status_d;
  csoi_pkg::csoi_option_s option_q, option_d;
  csoi_pkg::csoi_status_s wrStatus;
  logic [7:0] interrupt_control_word_q, interrupt_control_word_d;
  logic [7:0] pie_q, pie_d;
  logic [7:0] rdData_q, rdData_d;
  logic [7:0] dataAddr_q, dataAddr_d;
  logic [7:0] pullup_q, pullup_d;
  logic [7:0] tmr_q, tmr_d;
  logic [7:0] presc_q, presc_d;
  logic       wdogTick_q, wdogTick_d;
  logic       irq_q, irq_d;
  logic [1:0] extSync_q, extSync_d;
  logic [1:0] t0Sync_q, t0Sync_d;
  logic       extPrev_q, extPrev_d;
  logic       t0Prev_q, t0Prev_d;

  logic [7:0]          fullAddr;
  csoi_pkg::csoi_sel_e sel;
  logic [8:0]          sum;
  logic [4:0]          nib;
  logic                flagsTouched;
  logic                extEdge;
  logic                t0Edge;
  logic                srcTick;
  logic                prescTick;
  logic [7:0]          rateMask;
  logic [7:0]          pullupRaw;

  assign fullAddr = {status_q.directBankSelectLo, regAddr}; // R1
  assign sel      = regSel(fullAddr);
  assign wrStatus = regWrData;

  // ------------------------------------------------------------
  // pull-up per pin
  // ------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 8; g++)
    begin : gPull
      assign pullupRaw[g] = ~option_q.portbPullupDisable & portbLatch[g]; // R9
    end
  endgenerate

  // ------------------------------------------------------------
  // next-state logic
  // ------------------------------------------------------------
  always_comb
  begin
    status_d   = status_q;
    option_d   = option_q;
    interrupt_control_word_d   = interrupt_control_word_q;
    pie_d      = pie_q;
    tmr_d      = tmr_q;
    presc_d    = presc_q;
    wdogTick_d = 1'b0;
    extSync_d  = {extSync_q[0], extInterruptPin};
    t0Sync_d   = {t0Sync_q[0], timer0ClockPin};
    extPrev_d  = extSync_q[1];
    t0Prev_d   = t0Sync_q[1];
    dataAddr_d = fullAddr;
    pullup_d   = pullupRaw;

    // alu carry paths
    sum = 9'h000;
    nib = 5'h00;
    case (aluOp)
      csoi_pkg::ALU_ADD:
      begin
        sum = {1'b0, aluOperandF} + {1'b0, aluOperandW}; // R7
        nib = {1'b0, aluOperandF[3:0]} + {1'b0, aluOperandW[3:0]}; // R6
      end
      csoi_pkg::ALU_SUB:
      begin
        sum = {1'b0, aluOperandF} + {1'b0, ~aluOperandW} + 9'h001; // R7
        nib = {1'b0, aluOperandF[3:0]} + {1'b0, ~aluOperandW[3:0]} + 5'h01; // R6
      end
      default:
      begin
        sum = 9'h000;
        nib = 5'h00;
      end
    endcase
    flagsTouched = (aluOp != csoi_pkg::ALU_NONE);

    // software write
    if (regWrEn)
    begin
      case (sel)
        csoi_pkg::SEL_STATUS:
        begin
          status_d.indirectBankSelect = wrStatus.indirectBankSelect;
          status_d.directBankSelectHi = wrStatus.directBankSelectHi;
          status_d.directBankSelectLo = wrStatus.directBankSelectLo;
          if (!flagsTouched) // R21
          begin
            status_d.zeroFlag       = wrStatus.zeroFlag;
            status_d.digitCarryFlag = wrStatus.digitCarryFlag;
            status_d.carryFlag      = wrStatus.carryFlag;
          end
        end
        csoi_pkg::SEL_IRQCTL: interrupt_control_word_d = regWrData; // R19
        csoi_pkg::SEL_OPTION: option_d = regWrData;
        csoi_pkg::SEL_PIE:    pie_d = regWrData & csoi_pkg::PIE_MASK; // R20
        default:              interrupt_control_word_d = interrupt_control_word_q;
      endcase
    end

    // alu flag update
    case (aluOp)
      csoi_pkg::ALU_ADD, csoi_pkg::ALU_SUB:
      begin
        status_d.zeroFlag       = (sum[7:0] == 8'h00); // R5
        status_d.digitCarryFlag = nib[csoi_pkg::NIBBLE_MSB + 1]; // R6
        status_d.carryFlag      = sum[8]; // R7
      end
      csoi_pkg::ALU_LOGIC: status_d.zeroFlag = (aluLogicResult == 8'h00); // R5
      csoi_pkg::ALU_ROTL:  status_d.carryFlag = aluOperandF[7]; // R8
      csoi_pkg::ALU_ROTR:  status_d.carryFlag = aluOperandF[0]; // R8
      default:             status_d.carryFlag = status_d.carryFlag;
    endcase

    // power and watchdog status
    if (watchdogTimeout)
      status_d.timeoutStatusN = 1'b0; // R3
    else if (watchdogClearInstruction || sleepInstruction)
      status_d.timeoutStatusN = 1'b1; // R3
    if (watchdogClearInstruction)
      status_d.powerdownStatusN = 1'b1; // R4
    else if (sleepInstruction)
      status_d.powerdownStatusN = 1'b0; // R4

    // timer0 source and prescaler
    extEdge = option_q.extIrqEdgeSelect ? (extSync_q[1] & ~extPrev_q)
                                        : (~extSync_q[1] & extPrev_q); // R10
    t0Edge  = option_q.timer0SourceEdge ? (~t0Sync_q[1] & t0Prev_q)
                                        : (t0Sync_q[1] & ~t0Prev_q); // R12
    srcTick = option_q.timer0ClockSource ? t0Edge : instrCycleTick; // R11
    if (option_q.prescalerAssign) // R13
      rateMask = (8'h01 << option_q.prescalerRate) - 8'h01; // R14
    else
      rateMask = (8'h02 << option_q.prescalerRate) - 8'h01; // R14
    prescTick = 1'b0;
    if (option_q.prescalerAssign ? watchdogOscTick : srcTick)
    begin
      if ((presc_q & rateMask) == rateMask)
      begin
        presc_d   = 8'h00;
        prescTick = 1'b1;
      end
      else
        presc_d = presc_q + 8'h01;
    end
    if (option_q.prescalerAssign)
    begin
      wdogTick_d = prescTick; // R13
      if (srcTick)
        tmr_d = tmr_q + 8'h01;
    end
    else
    begin
      wdogTick_d = watchdogOscTick; // R13
      if (prescTick)
        tmr_d = tmr_q + 8'h01;
    end

    // event flags, set wins over a clearing write
    if (tmr_d == 8'h00 && tmr_q == 8'hff)
      interrupt_control_word_d[csoi_pkg::T0_FLAG] = 1'b1; // R16
    if (extEdge)
      interrupt_control_word_d[csoi_pkg::EXT_FLAG] = 1'b1; // R16
    if (portChangeEvent)
      interrupt_control_word_d[csoi_pkg::PC_FLAG] = 1'b1; // R16

    // interrupt request
    irq_d = interrupt_control_word_q[csoi_pkg::GLOBAL_EN_BIT] & // R17
            ((|(interrupt_control_word_q[csoi_pkg::EN_MSB:csoi_pkg::EN_LSB] & interrupt_control_word_q[csoi_pkg::FL_MSB:csoi_pkg::FL_LSB])) |
             (interrupt_control_word_q[csoi_pkg::PERIPH_EN_BIT] & (|(pie_q & periphFlags)))); // R18 R23

    // read back
    case (sel)
      csoi_pkg::SEL_STATUS: rdData_d = status_q;
      csoi_pkg::SEL_IRQCTL: rdData_d = interrupt_control_word_q;
      csoi_pkg::SEL_OPTION: rdData_d = option_q;
      csoi_pkg::SEL_PIE:    rdData_d = pie_q & csoi_pkg::PIE_MASK; // R20
      default:              rdData_d = 8'h00;
    endcase
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      status_q   <= csoi_pkg::STATUS_RST; // R3 R4
      option_q   <= csoi_pkg::OPTION_RST;
      interrupt_control_word_q   <= csoi_pkg::IRQCTL_RST;
      pie_q      <= csoi_pkg::PIE_RST;
      rdData_q   <= 8'h00;
      dataAddr_q <= 8'h00;
      pullup_q   <= 8'h00;
      tmr_q      <= 8'h00;
      presc_q    <= 8'h00;
      wdogTick_q <= 1'b0;
      irq_q      <= 1'b0;
      extSync_q  <= 2'b00;
      t0Sync_q   <= 2'b00;
      extPrev_q  <= 1'b0;
      t0Prev_q   <= 1'b0;
    end
    else
    begin
      status_q   <= status_d;
      option_q   <= option_d;
      interrupt_control_word_q   <= interrupt_control_word_d;
      pie_q      <= pie_d;
      rdData_q   <= rdData_d;
      dataAddr_q <= dataAddr_d;
      pullup_q   <= pullup_d;
      tmr_q      <= tmr_d;
      presc_q    <= presc_d;
      wdogTick_q <= wdogTick_d;
      irq_q      <= irq_d;
      extSync_q  <= extSync_d;
      t0Sync_q   <= t0Sync_d;
      extPrev_q  <= extPrev_d;
      t0Prev_q   <= t0Prev_d;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign regRdData     = rdData_q;
  assign dataAddr      = dataAddr_q;
  assign watchdogTick  = wdogTick_q;
  assign portbPullupOn = pullup_q;
  assign timer0Count   = tmr_q;
  assign statusWord    = status_q;
  assign irqRequest    = irq_q;

endmodule

// >>> csoi_regs_chk.sv
// assertions on the status, option and interrupt register group
`timescale 1ns/1ps
module csoi_regs_chk
(
  // clock and reset
  input wire logic              clk,
  input wire logic              reset_n,
  // register access
  input wire logic [6:0]        regAddr,
  input wire logic              regWrEn,
  input wire logic [7:0]        dataAddr,
  // alu, port and status
  input csoi_pkg::csoi_alu_e    aluOp,
  input wire logic [7:0]        aluOperandF,
  input wire logic [7:0]        aluOperandW,
  input wire logic [7:0]        aluLogicResult,
  input wire logic [7:0]        portbLatch,
  input wire logic [7:0]        portbPullupOn,
  input csoi_pkg::csoi_status_s statusWord
);
  // ----
  // expected alu sums
  // ----
  logic [8:0] sumA;
  logic [8:0] sumS;
  logic [4:0] nibA;
  logic [4:0] nibS;
  assign sumA = {1'b0, aluOperandF} + {1'b0, aluOperandW};
  assign sumS = {1'b0, aluOperandF} + {1'b0, ~aluOperandW} + 9'h001;
  assign nibA = {1'b0, aluOperandF[3:0]} + {1'b0, aluOperandW[3:0]};
  assign nibS = {1'b0, aluOperandF[3:0]} + {1'b0, ~aluOperandW[3:0]} + 5'h01;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  // ----
  // properties
  // ----
  a_bank_decode: assert property (1'b1 |=>
    dataAddr == {$past(statusWord.directBankSelectLo), $past(regAddr)}) else $error("bad effective address");
  a_add_flags: assert property (aluOp == csoi_pkg::ALU_ADD |=>
    statusWord[2:0] == {($past(sumA[7:0]) == 8'h00), $past(nibA[4]), $past(sumA[8])}) else $error("bad add flags");
  a_sub_flags: assert property (aluOp == csoi_pkg::ALU_SUB |=>
    statusWord[2:0] == {($past(sumS[7:0]) == 8'h00), $past(nibS[4]), $past(sumS[8])}) else $error("bad sub flags");
  a_rotl_carry: assert property (aluOp == csoi_pkg::ALU_ROTL |=>
    statusWord.carryFlag == $past(aluOperandF[7])) else $error("bad rotate left carry");
  a_rotr_carry: assert property (aluOp == csoi_pkg::ALU_ROTR |=>
    statusWord.carryFlag == $past(aluOperandF[0])) else $error("bad rotate right carry");
  a_logic_zero: assert property (aluOp == csoi_pkg::ALU_LOGIC |=>
    statusWord.zeroFlag == ($past(aluLogicResult) == 8'h00)) else $error("bad logic zero");
  a_flags_hold: assert property (aluOp == csoi_pkg::ALU_NONE && !(regWrEn && regAddr == 7'h03) |=>
    $stable(statusWord[2:0])) else $error("flags changed without cause");
  a_pullup_latch: assert property (1'b1 |=>
    (portbPullupOn & ~$past(portbLatch)) == 8'h00) else $error("pull-up on a cleared latch");
endmodule

bind csoi_regs csoi_regs_chk u_chk
(
  .clk(clk), .reset_n(reset_n), .regAddr(regAddr), .regWrEn(regWrEn), .dataAddr(dataAddr), .aluOp(aluOp),
  .aluOperandF(aluOperandF), .aluOperandW(aluOperandW), .aluLogicResult(aluLogicResult),
  .portbLatch(portbLatch), .portbPullupOn(portbPullupOn), .statusWord(statusWord)
);

// >>> testbench.sv
// self-checking testbench for the status, option and interrupt register group
`timescale 1ns/1ps
module testbench;
  // ----
  // signals
  // ----
  logic                   clk = 1'b0;
  logic                   resetN = 1'b0;
  logic [6:0]             ra = 7'h00;
  logic                   we = 1'b0;
  logic [7:0]             wd = 8'h00;
  csoi_pkg::csoi_alu_e    op = csoi_pkg::ALU_NONE;
  logic [7:0]             fo = 8'h00;
  logic [7:0]             wo = 8'h00;
  logic [2:0]             evt = 3'h0;
  logic [2:0]             tk = 3'h0;
  logic                   pin = 1'b0;
  logic                   pce = 1'b0;
  logic [7:0]             pl = 8'ha5;
  logic [7:0]             pf = 8'h00;
  logic [2:0]             fl = 3'h0;
  logic [7:0]             rdd, da, pu, t0c, t0;
  csoi_pkg::csoi_status_s st;
  logic                   wt, irq;
  int                     errors = 0, checks_done = 0, wdTicks = 0, w0, e;

  csoi_regs uut
  (
    .clk(clk), .reset_n(resetN), .regAddr(ra), .regWrEn(we), .regWrData(wd), .regRdData(rdd), .dataAddr(da),
    .aluOp(op), .aluOperandF(fo), .aluOperandW(wo), .aluLogicResult(fo), .watchdogClearInstruction(evt[2]),
    .sleepInstruction(evt[0]), .watchdogTimeout(evt[1]), .watchdogOscTick(tk[1]), .watchdogTick(wt),
    .extInterruptPin(pin), .timer0ClockPin(tk[2]), .instrCycleTick(tk[0]), .portChangeEvent(pce),
    .portbLatch(pl), .periphFlags(pf), .portbPullupOn(pu), .timer0Count(t0c), .statusWord(st), .irqRequest(irq)
  );

  always #4 clk = ~clk;
  always @(posedge clk)
    if (wt === 1'b1)
      wdTicks <= wdTicks + 1;
  // ----
  // tasks
  // ----
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      errors++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    ra = a;
    wd = d;
    we = 1'b1;
    @(negedge clk);
    we = 1'b0;
    @(negedge clk);
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] exp);
    ra = a;
    @(negedge clk);
    check(rdd, exp);
  endtask
  task automatic ci(input logic [7:0] exp);
    @(negedge clk);
    check({7'h00, irq}, exp);
  endtask
  task automatic alu(input csoi_pkg::csoi_alu_e o, input logic [7:0] f, input logic [7:0] w, input logic wen);
    logic [8:0] s;
    logic [4:0] n;
    op = o;
    fo = f;
    wo = w;
    ra = 7'h03;
    wd = 8'h27;
    we = wen;
    s = (o == csoi_pkg::ALU_SUB) ? {1'b0, f} + {1'b0, ~w} + 9'h001 : {1'b0, f} + {1'b0, w};
    n = (o == csoi_pkg::ALU_SUB) ? {1'b0, f[3:0]} + {1'b0, ~w[3:0]} + 5'h01 : {1'b0, f[3:0]} + {1'b0, w[3:0]};
    if (o == csoi_pkg::ALU_ADD || o == csoi_pkg::ALU_SUB)
      fl = {(s[7:0] == 8'h00), n[4], s[8]};
    if (o == csoi_pkg::ALU_LOGIC)
      fl[2] = (f == 8'h00);
    if (o == csoi_pkg::ALU_ROTL || o == csoi_pkg::ALU_ROTR)
      fl[0] = (o == csoi_pkg::ALU_ROTL) ? f[7] : f[0];
    @(negedge clk);
    op = csoi_pkg::ALU_NONE;
    we = 1'b0;
    check({5'h00, st[2:0]}, {5'h00, fl});
    @(negedge clk);
  endtask
  task automatic pulses(input int b, input int cnt);
    repeat (cnt)
    begin
      tk[b] = 1'b1;
      repeat (b == 2 ? 3 : 1) @(negedge clk);
      tk[b] = 1'b0;
      repeat (3) @(negedge clk);
    end
    repeat (4) @(negedge clk);
  endtask
  task automatic wait_irq;
    for (int i = 0; i < 12 && irq !== 1'b1; i++)
      @(negedge clk);
    if (irq !== 1'b1)
    begin
      errors++;
      $display("mismatch at %0t: interrupt request timed out", $time);
      wrap_up();
    end
  endtask
  // ----
  // sequence
  // ----
  initial
  begin
    repeat (16) @(negedge clk);
    resetN = 1'b1;
    check(st, 8'h18);
    rd(7'h03, 8'h18);
    rd(7'h05, 8'h00);
    check(da, 8'h05);
    wr(7'h03, 8'h27);
    check(st, 8'h3f);
    wr(7'h03, 8'h20);
    rd(7'h03, 8'h38);
    rd(7'h0b, 8'h00);
    rd(7'h01, 8'hff);
    wr(7'h0c, 8'hff);
    rd(7'h0c, 8'h4f);
    check(da, 8'h8c);
    wr(7'h0c, 8'h00);
    $display("register access test done");
    alu(csoi_pkg::ALU_ADD, 8'h0f, 8'h01, 1'b1);
    alu(csoi_pkg::ALU_ADD, 8'hff, 8'h01, 1'b0);
    alu(csoi_pkg::ALU_SUB, 8'h05, 8'h05, 1'b0);
    alu(csoi_pkg::ALU_SUB, 8'h03, 8'h05, 1'b1);
    alu(csoi_pkg::ALU_ROTL, 8'h80, 8'h00, 1'b0);
    alu(csoi_pkg::ALU_ROTR, 8'h02, 8'h00, 1'b0);
    alu(csoi_pkg::ALU_LOGIC, 8'h00, 8'h00, 1'b0);
    alu(csoi_pkg::ALU_LOGIC, 8'h10, 8'h00, 1'b0);
    $display("flag test done");
    for (e = 0; e < 3; e++)
    begin
      evt = 3'h1 << e;
      @(negedge clk);
      evt = 3'h0;
      check({6'h00, st.timeoutStatusN, st.powerdownStatusN}, e == 2 ? 8'h03 : (e == 0 ? 8'h02 : 8'h00));
      @(negedge clk);
    end
    $display("power event test done");
    pce = 1'b1;
    @(negedge clk);
    pce = 1'b0;
    rd(7'h0b, 8'h01);
    ci(8'h00);
    wr(7'h0b, 8'h89);
    ci(8'h01);
    wr(7'h0b, 8'h09);
    ci(8'h00);
    pf = 8'h01;
    wr(7'h0c, 8'h01);
    wr(7'h0b, 8'h80);
    ci(8'h00);
    wr(7'h0b, 8'hc0);
    ci(8'h01);
    wr(7'h0c, 8'h00);
    for (e = 1; e >= 0; e--)
    begin
      wr(7'h01, {1'b1, e[0], 6'h08});
      wr(7'h0b, 8'h90);
      @(negedge clk);
      pin = e[0];
      wait_irq();
      rd(7'h0b, 8'h92);
    end
    wr(7'h0b, 8'h00);
    $display("interrupt test done");
    wr(7'h01, 8'hc8);
    t0 = t0c;
    pulses(0, 5);
    check(pu, 8'h00);
    check(t0c, t0 + 8'h05);
    w0 = wdTicks;
    wr(7'h01, 8'hc9);
    pulses(1, 4);
    check(8'(wdTicks - w0), 8'h02);
    wr(7'h01, 8'h40);
    t0 = t0c;
    pulses(0, 4);
    check(pu, 8'ha5);
    check(t0c, t0 + 8'h02);
    wr(7'h01, 8'hf8);
    t0 = t0c;
    pulses(2, 3);
    check(t0c, t0 + 8'h03);
    wr(7'h01, 8'he8);
    t0 = t0c;
    pulses(2, 2);
    check(t0c, t0 + 8'h02);
    wr(7'h01, 8'hc8);
    t0 = t0c;
    tk[0] = 1'b1;
    repeat (256) @(negedge clk);
    tk[0] = 1'b0;
    check(t0c, t0);
    rd(7'h0b, 8'h04);
    $display("timer option test done");
    wrap_up();
  end
endmodule
